//--- hdl/ptsr_sensor.sv
// Sensor end: encodes pressure and temperature into counts, schedules
// measurements and shifts the result word out on the shared pins.
// Assumes the host honours link rates, select-to-clock and bus free times.
// Operation
// - Pressure is 14-bit count, zero to all-ones
// - Ten-percent window: 1638 to 14746, mid 8192
// - Five-percent window: 819 to 15563
// - Temperature 11-bit: -50C zero, 150C 2047
// - Differential: equal ports give half scale
// - Gauge: zero gauge equals lower rated pressure
// - One pin set serves both protocols (here the I2C role drives only the alert; the data pin stays released)
// - Reduced pin variant has no alert line
// - Low power: request wakes, measures, loads
// - Low power: powers down, holds until fetched
// - I2C master clock 100 to 400 kHz
// - SPI master clock 50 to 800 kHz
// - SPI: 2.5 us select to first edge
// - I2C: 2 us idle between stop, start
// - SPI: 2 us select high between transfers
// - First result within 8.4 ms, then 0.5 ms
`timescale 1ns/1ps
module ptsr_sensor
  import ptsr_pkg::*;
#(
  parameter bit PROTO_SPI = 1'b1,          // 1: SPI pin roles, 0: I2C pin roles
  parameter bit WIN_FIVE = 1'b0,           // 1: five-percent window, 0: ten-percent
  parameter bit LOW_POWER = 1'b0,          // After the first result, measure only on request
  parameter bit REDUCED_PIN = 1'b0,        // No alert line fitted
  parameter int START_CYCLES = int'(START_CYC),
  parameter int UPDATE_CYCLES = int'(UPDATE_CYC)
) (
  input wire logic clk,                    // Core clock
  input wire logic rstn,                   // Power-on reset, active low
  input wire logic signed [19:0] press_in, // Pressure: 0 lower rated, 2^16 upper rated
  input wire logic signed [15:0] temp_in,  // Temperature in tenths of a degree C
  ptsr_link_if.dev link,                   // Shared pins
  output logic powered_reg,                // Sensor and calibration logic powered
  output logic fresh_reg                   // Result not yet fetched
);

  // ----------------------------------------
  // Count encoding
  // ----------------------------------------
  logic [13:0] p_cnt;
  logic [10:0] t_cnt;
  logic signed [39:0] p_prod;
  logic signed [39:0] p_sum;
  logic signed [31:0] t_prod;
  logic signed [31:0] t_quo;
  logic [13:0] p_lo;
  logic [13:0] p_hi;

  // Linear map from rated span onto the chosen window, clipped at the rails.
  // Gauge parts put zero gauge at fraction 0; differential parts put equal
  // ports at fraction 0.5, which lands on midscale 8192 with the ten-percent window and on 8191 with five-percent.
  always_comb begin
    p_lo = WIN_FIVE ? P5_LO : P10_LO;
    p_hi = WIN_FIVE ? P5_HI : P10_HI;
    p_prod = 40'(press_in) * 40'(signed'({1'b0, p_hi - p_lo}));
    p_sum = 40'(signed'({1'b0, p_lo})) + (p_prod >>> FRAC_W);
    if (p_sum < 40'(signed'({1'b0, P_ZERO}))) begin
      p_cnt = P_ZERO;
    end else if (p_sum > 40'(signed'({1'b0, P_FULL}))) begin
      p_cnt = P_FULL;
    end else begin
      p_cnt = p_sum[13:0];
    end
    t_prod = (32'(temp_in) - 32'(T_MIN_DC)) * 32'(T_FULL);
    t_quo = t_prod / 32'(T_SPAN_DC);
    if (t_quo < 0) begin
      t_cnt = 11'h000;
    end else if (t_quo > 32'(T_FULL)) begin
      t_cnt = T_FULL;
    end else begin
      t_cnt = t_quo[10:0];
    end
  end

  // ----------------------------------------
  // Pin synchronisers (core clock)
  // ----------------------------------------
  logic ss_m_reg, ss_s_reg, ss_d_reg;
  logic tg_m_reg, tg_s_reg, tg_seen_reg;
  logic link_tog_reg;
  logic ss_rise;

  // Select pin and the frame toggle pass two flops before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ss_m_reg <= 1'b1;
      ss_s_reg <= 1'b1;
      ss_d_reg <= 1'b1;
      tg_m_reg <= 1'b0;
      tg_s_reg <= 1'b0;
    end else begin
      ss_m_reg <= link.ss_line;
      ss_s_reg <= ss_m_reg;
      ss_d_reg <= ss_s_reg;
      tg_m_reg <= link_tog_reg;
      tg_s_reg <= tg_m_reg;
    end
  end

  assign ss_rise = PROTO_SPI && ss_s_reg && !ss_d_reg;

  // ----------------------------------------
  // Measurement scheduler
  // ----------------------------------------
  typedef enum logic [1:0] {
    PTSR_BOOT = 2'b00,
    PTSR_SLEEP = 2'b01,
    PTSR_MEASURE = 2'b10
  } ptsr_state_t;

  ptsr_state_t state_reg, state_next;
  logic [31:0] tmr_reg, tmr_next;
  logic [31:0] word_reg, word_next;
  logic tg_seen_next, fresh_next, powered_next;
  logic tmr_done, load, mreq, fetch;

  // A frame with no clock edges is a request; one with edges is a fetch
  assign mreq = ss_rise && (tg_s_reg == tg_seen_reg);
  assign fetch = ss_rise && (tg_s_reg != tg_seen_reg);
  assign tmr_done = (tmr_reg == 32'h0000_0000);
  // Loads wait while select is low so the word holds still for the link side
  assign load = tmr_done && (state_reg != PTSR_SLEEP) && (!PROTO_SPI || ss_s_reg);

  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_done ? tmr_reg : tmr_reg - 32'h0000_0001;
    word_next = word_reg;
    fresh_next = fresh_reg;
    tg_seen_next = ss_rise ? tg_s_reg : tg_seen_reg;
    if (fetch) begin
      fresh_next = 1'b0;
      word_next[31:30] = ST_STALE;
    end
    unique case (state_reg)
      PTSR_BOOT, PTSR_MEASURE: begin
        if (load) begin
          // Load wins over a fetch in the same cycle
          word_next = {ST_FRESH, p_cnt, t_cnt, PAD};
          fresh_next = 1'b1;
          tmr_next = 32'(UPDATE_CYCLES - 1);
          state_next = LOW_POWER ? PTSR_SLEEP : PTSR_MEASURE;
        end
      end
      PTSR_SLEEP: begin
        if (mreq) begin
          tmr_next = 32'(UPDATE_CYCLES - 1);
          state_next = PTSR_MEASURE;
        end
      end
      default: begin
        state_next = PTSR_BOOT;
      end
    endcase
    powered_next = (state_next != PTSR_SLEEP);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= PTSR_BOOT;
      tmr_reg <= 32'(START_CYCLES - 1);
      word_reg <= {ST_STALE, 30'h0000_0000};
      fresh_reg <= 1'b0;
      powered_reg <= 1'b1;
      tg_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      word_reg <= word_next;
      fresh_reg <= fresh_next;
      powered_reg <= powered_next;
      tg_seen_reg <= tg_seen_next;
    end
  end

  // ----------------------------------------
  // Alert pin (I2C role only)
  // ----------------------------------------
  logic al_o_reg, al_oe_reg;

  // In the I2C role the select pin becomes a data-ready output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      al_o_reg <= 1'b0;
      al_oe_reg <= 1'b0;
    end else begin
      al_o_reg <= fresh_next;
      al_oe_reg <= !PROTO_SPI && !REDUCED_PIN;
    end
  end

  assign link.al_d_o = al_o_reg;
  assign link.al_d_oe = al_oe_reg;

  // ----------------------------------------
  // Link side (serial clock domain)
  // ----------------------------------------
  logic [5:0] bit_reg, bit_next;
  logic sda_o_reg, sda_o_next;
  logic sda_oe_reg, sda_oe_next;
  logic frame_cs_hi;

  // The word is only read after select has been low for 2.5 us, by which
  // time the core side has frozen it: it is quasi-static here.
  always_comb begin
    sda_oe_next = 1'b1;
    if (bit_reg < 6'(WORD_W)) begin
      sda_o_next = word_reg[5'(WORD_W - 1) - bit_reg[4:0]];
      bit_next = bit_reg + 6'h01;
    end else begin
      sda_o_next = 1'b1;
      bit_next = bit_reg;
    end
  end

  assign frame_cs_hi = link.ss_line || !PROTO_SPI;

  // Select high clears the frame; no sclk edge is needed for that
  always_ff @(posedge link.sclk or posedge frame_cs_hi) begin
    if (frame_cs_hi) begin
      bit_reg <= 6'h00;
      sda_o_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
    end else begin
      bit_reg <= bit_next;
      sda_o_reg <= sda_o_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // One toggle per clocked frame tells the core a fetch happened
  always_ff @(posedge link.sclk or negedge rstn) begin
    if (!rstn) begin
      link_tog_reg <= 1'b0;
    end else if (bit_reg == 6'h00 && !frame_cs_hi) begin
      link_tog_reg <= !link_tog_reg;
    end
  end

  assign link.sda_d_o = sda_o_reg;
  assign link.sda_d_oe = sda_oe_reg;

endmodule

//--- hdl/ptsr_pkg.sv
// Shared constants for the pressure/temperature readout pair: count encoding,
// result word layout and timing figures.
// Assumes both ends run their core clock at CLK_HZ.
package ptsr_pkg;

  // ----------------------------------------
  // Clock and timing figures
  // ----------------------------------------
  localparam longint CLK_HZ = 200_000_000;
  localparam longint CLK_MHZ = CLK_HZ / 1_000_000;
  localparam longint T_START_NS = 8_400_000;   // Longest time to first result, 8.4 ms
  localparam longint T_UPDATE_NS = 500_000;    // Update period, 0.5 ms
  localparam longint T_HDSS_NS = 2_500;        // Least select-to-first-edge, 2.5 us
  localparam longint T_BUS_NS = 2_000;         // Least bus free time, 2 us
  localparam longint T_SUSS_NS = 100;          // Least last-edge-to-select-rise, 0.1 us
  localparam longint SCLK_DEF_HZ = 400_000;    // Host link rate, inside 50..800 kHz
  // Longest times round down, least times round up
  localparam longint START_CYC = T_START_NS * CLK_MHZ / 1000;
  localparam longint UPDATE_CYC = T_UPDATE_NS * CLK_MHZ / 1000;
  localparam longint HDSS_CYC = (T_HDSS_NS * CLK_MHZ + 999) / 1000;
  localparam longint BUS_CYC = (T_BUS_NS * CLK_MHZ + 999) / 1000;
  localparam longint SUSS_CYC = (T_SUSS_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // Count encoding
  // ----------------------------------------
  localparam int P_W = 14;
  localparam int T_W = 11;
  localparam logic [13:0] P_ZERO = 14'h0000;
  localparam logic [13:0] P_FULL = 14'h3fff;
  localparam logic [13:0] P10_LO = 14'h0666;   // Ten-percent window, lower rated pressure
  localparam logic [13:0] P10_HI = 14'h399a;   // Ten-percent window, upper rated pressure
  localparam logic [13:0] P_MID = 14'h2000;    // Midscale: equal ports on differential parts, ten-percent window
  localparam logic [13:0] P5_LO = 14'h0333;    // Five-percent window, lower rated pressure
  localparam logic [13:0] P5_HI = 14'h3ccb;    // Five-percent window, upper rated pressure
  localparam logic [10:0] T_FULL = 11'h7ff;
  localparam int T_MIN_DC = -500;              // -50 C in tenths of a degree
  localparam int T_SPAN_DC = 2000;             // -50 C .. 150 C in tenths
  localparam int FRAC_W = 16;                  // Pressure input fraction bits

  // ----------------------------------------
  // Result word: status, pressure, temperature, padding
  // ----------------------------------------
  localparam int WORD_W = 32;
  localparam int BITCNT_W = 6;
  localparam logic [1:0] ST_FRESH = 2'h0;
  localparam logic [1:0] ST_STALE = 2'h2;
  localparam logic [4:0] PAD = 5'h00;

endpackage

//--- hdl/ptsr_link_if.sv
// Shared three-pin link between the sensor end and the host end.
// Resolves the tri-state data pin and the shared select/alert pin from enables.
`timescale 1ns/1ps
interface ptsr_link_if;
  logic sclk;       // Serial clock, made by the host
  logic ss_h_o;     // Host drive value on select pin
  logic ss_h_oe;    // Host drives select pin
  logic al_d_o;     // Sensor drive value on alert pin
  logic al_d_oe;    // Sensor drives alert pin
  logic sda_d_o;    // Sensor drive value on data pin
  logic sda_d_oe;   // Sensor drives data pin
  logic ss_line;    // Resolved select/alert pin level
  logic sda_line;   // Resolved data pin level

  // Undriven pins float high through pull-ups
  assign ss_line = ss_h_oe ? ss_h_o : (al_d_oe ? al_d_o : 1'b1);
  assign sda_line = sda_d_oe ? sda_d_o : 1'b1;

  modport dev (input sclk, input ss_line, input sda_line,
               output al_d_o, output al_d_oe, output sda_d_o, output sda_d_oe);
  modport host (output sclk, output ss_h_o, output ss_h_oe,
                input ss_line, input sda_line);
endinterface

//--- hdl/ptsr_host.sv
// Host end: SPI master that makes the serial clock by division and issues
// measurement requests (empty frames) and data fetches (32-bit frames).
// Assumes the sensor end is in the SPI pin role.
`timescale 1ns/1ps
module ptsr_host
  import ptsr_pkg::*;
#(
  parameter int HALF_CYCLES = int'(CLK_HZ / (2 * SCLK_DEF_HZ))  // Half sclk period
) (
  input wire logic clk,               // Core clock
  input wire logic rstn,              // Reset, active low
  input wire logic req_measure,       // Pulse: send a measurement request
  input wire logic req_fetch,         // Pulse: send a data fetch
  ptsr_link_if.host link,             // Shared pins
  output logic busy_reg,              // Transfer or bus free time in progress
  output logic done_reg,              // Pulse: fetch result valid
  output logic [1:0] status_reg,      // Fetched status
  output logic [13:0] press_reg,      // Fetched pressure count
  output logic [10:0] temp_reg        // Fetched temperature count
);

  // ----------------------------------------
  // Data pin synchroniser
  // ----------------------------------------
  logic sda_m_reg, sda_s_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      sda_m_reg <= link.sda_line;
      sda_s_reg <= sda_m_reg;
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    PTSR_H_IDLE = 3'b000,
    PTSR_H_SETUP = 3'b001,
    PTSR_H_CLOCK = 3'b010,
    PTSR_H_HOLD = 3'b011,
    PTSR_H_FREE = 3'b100
  } ptsr_hstate_t;

  ptsr_hstate_t st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [5:0] bits_reg, bits_next;
  logic [31:0] sh_reg, sh_next;
  logic fetch_reg, fetch_next;
  logic sclk_reg, sclk_next;
  logic ss_reg, ss_next;
  logic busy_next, done_next;
  logic [1:0] status_next;
  logic [13:0] press_next;
  logic [10:0] temp_next;
  logic cnt_done;

  assign cnt_done = (cnt_reg == 16'h0000);

  // Sensor shifts on the rising edge; the host samples just before falling,
  // a half period later, which covers the two-flop delay on the data pin.
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_done ? cnt_reg : cnt_reg - 16'h0001;
    bits_next = bits_reg;
    sh_next = sh_reg;
    fetch_next = fetch_reg;
    sclk_next = sclk_reg;
    ss_next = ss_reg;
    done_next = 1'b0;
    status_next = status_reg;
    press_next = press_reg;
    temp_next = temp_reg;
    unique case (st_reg)
      PTSR_H_IDLE: begin
        if (req_measure || req_fetch) begin
          fetch_next = req_fetch;
          ss_next = 1'b0;
          cnt_next = 16'(HDSS_CYC - 1);
          st_next = PTSR_H_SETUP;
        end
      end
      PTSR_H_SETUP: begin
        if (cnt_done) begin
          bits_next = 6'h00;
          // The default 400 kHz rate sits inside both the I2C and SPI ranges
          cnt_next = 16'(HALF_CYCLES - 1);
          st_next = fetch_reg ? PTSR_H_CLOCK : PTSR_H_HOLD;
        end
      end
      PTSR_H_CLOCK: begin
        if (cnt_done) begin
          cnt_next = 16'(HALF_CYCLES - 1);
          sclk_next = !sclk_reg;
          if (sclk_reg) begin
            sh_next = {sh_reg[30:0], sda_s_reg};
            bits_next = bits_reg + 6'h01;
            if (bits_reg == 6'(WORD_W - 1)) begin
              cnt_next = 16'(SUSS_CYC - 1);
              st_next = PTSR_H_HOLD;
            end
          end
        end
      end
      PTSR_H_HOLD: begin
        if (cnt_done) begin
          ss_next = 1'b1;
          cnt_next = 16'(BUS_CYC - 1);
          st_next = PTSR_H_FREE;
          if (fetch_reg) begin
            done_next = 1'b1;
            status_next = sh_reg[31:30];
            press_next = sh_reg[29:16];
            temp_next = sh_reg[15:5];
          end
        end
      end
      PTSR_H_FREE: begin
        if (cnt_done) begin
          st_next = PTSR_H_IDLE;
        end
      end
      default: begin
        st_next = PTSR_H_IDLE;
      end
    endcase
    busy_next = (st_next != PTSR_H_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= PTSR_H_IDLE;
      cnt_reg <= 16'h0000;
      bits_reg <= 6'h00;
      sh_reg <= 32'h0000_0000;
      fetch_reg <= 1'b0;
      sclk_reg <= 1'b0;
      ss_reg <= 1'b1;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      status_reg <= 2'h0;
      press_reg <= 14'h0000;
      temp_reg <= 11'h000;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bits_reg <= bits_next;
      sh_reg <= sh_next;
      fetch_reg <= fetch_next;
      sclk_reg <= sclk_next;
      ss_reg <= ss_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      status_reg <= status_next;
      press_reg <= press_next;
      temp_reg <= temp_next;
    end
  end

  assign link.sclk = sclk_reg;
  assign link.ss_h_o = ss_reg;
  assign link.ss_h_oe = 1'b1;

endmodule

//--- tb/ptsr_chk.sv
// Checker for one link between a sensor end and a host end.
// Assumes it sees the resolved pins, sampled on the host core clock.
`timescale 1ns/1ps
module ptsr_chk
  import ptsr_pkg::*;
#(
  parameter int HALF = 125      // Host half sclk period, core cycles
) (
  input wire logic clk,         // Host core clock
  input wire logic rstn,        // Reset, active low
  input wire logic sclk,        // Link clock
  input wire logic ss_line,     // Resolved select pin
  input wire logic al_d_oe,     // Sensor alert enable
  input wire logic sda_d_oe     // Sensor data enable
);
  localparam int HDSS_N = int'(HDSS_CYC);
  localparam int BUS_N = int'(BUS_CYC);
  localparam int PER_N = 2 * HALF - 1;
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [15:0] low_cnt_reg, low_cnt_next, high_cnt_reg, high_cnt_next, per_cnt_reg, per_cnt_next;
  logic [5:0] rise_cnt_reg, rise_cnt_next;
  logic sclk_d_reg, seen_reg, seen_next, rise;
  // Idle time saturates so a long pause cannot wrap into a false short gap
  always_comb begin
    rise = sclk && !sclk_d_reg;
    low_cnt_next = ss_line ? 16'h0000 : low_cnt_reg + 16'h0001;
    high_cnt_next = !ss_line ? 16'h0000 :
                    ((high_cnt_reg == 16'hffff) ? high_cnt_reg : high_cnt_reg + 16'h0001);
    per_cnt_next = (ss_line || rise) ? 16'h0000 : per_cnt_reg + 16'h0001;
    seen_next = ss_line ? 1'b0 : (seen_reg || rise);
    rise_cnt_next = ss_line ? 6'h00 : rise_cnt_reg + {5'h00, rise};
  end
  // Registers only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_reg <= 1'b0;
      low_cnt_reg <= 16'h0000;
      high_cnt_reg <= 16'hffff;
      per_cnt_reg <= 16'h0000;
      seen_reg <= 1'b0;
      rise_cnt_reg <= 6'h00;
    end else begin
      sclk_d_reg <= sclk;
      low_cnt_reg <= low_cnt_next;
      high_cnt_reg <= high_cnt_next;
      per_cnt_reg <= per_cnt_next;
      seen_reg <= seen_next;
      rise_cnt_reg <= rise_cnt_next;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_frame_open; $fell(ss_line); endsequence
  sequence s_quiet; (!ss_line && !sclk && !sda_d_oe) [*8]; endsequence
  property p_open_quiet; s_frame_open |-> s_quiet; endproperty
  property p_sel_to_edge; $rose(sclk) |-> low_cnt_reg >= HDSS_N; endproperty
  property p_period; $rose(sclk) && seen_reg |-> per_cnt_reg == PER_N; endproperty
  property p_bits; $rose(ss_line) |-> rise_cnt_reg == 6'h00 || rise_cnt_reg == 6'h20; endproperty
  property p_bus_free; s_frame_open |-> high_cnt_reg >= BUS_N; endproperty
  property p_idle_clk; ss_line |-> !sclk; endproperty
  property p_no_alert; !al_d_oe; endproperty
  property p_release; $rose(ss_line) |-> ##[1:60] !sda_d_oe; endproperty
  a_open_quiet: assert property (p_open_quiet) else $error("link active right after select");
  a_sel_to_edge: assert property (p_sel_to_edge) else $error("first edge too soon");
  a_period: assert property (p_period) else $error("link clock period wrong");
  a_bits: assert property (p_bits) else $error("frame neither empty nor 32 bits");
  a_bus_free: assert property (p_bus_free) else $error("select high too briefly");
  a_idle_clk: assert property (p_idle_clk) else $error("link clock runs outside frame");
  a_no_alert: assert property (p_no_alert) else $error("alert driven in select role");
  a_release: assert property (p_release) else $error("data pin not released");
  c_fetch: cover property ($rose(ss_line) && rise_cnt_reg == 6'h20);
endmodule

//--- tb/ptsr_tb.sv
// Bench: a standard ten-percent pair and a low power five-percent pair.
// Assumes the host speaks SPI; two more sensors sit in the I2C role with no host.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module ptsr_tb;
  import ptsr_pkg::*;
  localparam int HALF = 125;    // 800 kHz, the fastest legal link rate
  localparam int UPD = 200;     // Shortened update period, sensor cycles
  logic clk = 1'b0;
  logic dclk = 1'b0;
  logic rstn = 1'b0;
  logic rm_a = 1'b0, rf_a = 1'b0, rm_b = 1'b0, rf_b = 1'b0;
  logic signed [19:0] prs_a = 20'h00000, prs_b = 20'h00000;
  logic signed [15:0] tmp_a = 16'hfe0c, tmp_b = 16'h05dc;
  logic busy_a, done_a, busy_b, done_b, pw_a, fr_a, pw_b, fr_b, fr_c;
  logic [1:0] st_a, st_b;
  logic [13:0] pr_a, pr_b;
  logic [10:0] tp_a, tp_b;
  logic [31:0] cap_a = 32'h0, cap_b = 32'h0;
  int errors = 0;
  int checked = 0;
  // ----------------------------------------
  // Clocks, pairs, checker
  // ----------------------------------------
  always #2.5 clk = ~clk;
  always #24 dclk = ~dclk;
  ptsr_link_if link_a();
  ptsr_link_if link_b();
  ptsr_sensor #(.START_CYCLES(400), .UPDATE_CYCLES(UPD)) u_ptsr_sensor (.clk(dclk),
    .rstn(rstn), .press_in(prs_a), .temp_in(tmp_a), .link(link_a), .powered_reg(pw_a),
    .fresh_reg(fr_a));
  ptsr_sensor #(.WIN_FIVE(1'b1), .LOW_POWER(1'b1), .START_CYCLES(400), .UPDATE_CYCLES(UPD))
    u_ptsr_sensor_b (.clk(dclk), .rstn(rstn), .press_in(prs_b), .temp_in(tmp_b),
    .link(link_b), .powered_reg(pw_b), .fresh_reg(fr_b));
  ptsr_host #(.HALF_CYCLES(HALF)) u_ptsr_host (.clk(clk), .rstn(rstn), .req_measure(rm_a),
    .req_fetch(rf_a), .link(link_a), .busy_reg(busy_a), .done_reg(done_a),
    .status_reg(st_a), .press_reg(pr_a), .temp_reg(tp_a));
  ptsr_host #(.HALF_CYCLES(HALF)) u_ptsr_host_b (.clk(clk), .rstn(rstn), .req_measure(rm_b),
    .req_fetch(rf_b), .link(link_b), .busy_reg(busy_b), .done_reg(done_b),
    .status_reg(st_b), .press_reg(pr_b), .temp_reg(tp_b));
  // I2C-role sensors: no host attached, host pins left released
  ptsr_link_if link_c();
  ptsr_link_if link_d();
  assign link_c.sclk = 1'b0;
  assign link_c.ss_h_o = 1'b1;
  assign link_c.ss_h_oe = 1'b0;
  assign link_d.sclk = 1'b0;
  assign link_d.ss_h_o = 1'b1;
  assign link_d.ss_h_oe = 1'b0;
  ptsr_sensor #(.PROTO_SPI(1'b0), .START_CYCLES(400), .UPDATE_CYCLES(UPD)) u_ptsr_sensor_c (
    .clk(dclk), .rstn(rstn), .press_in(prs_a), .temp_in(tmp_a), .link(link_c),
    .powered_reg(), .fresh_reg(fr_c));
  ptsr_sensor #(.PROTO_SPI(1'b0), .REDUCED_PIN(1'b1), .START_CYCLES(400), .UPDATE_CYCLES(UPD))
    u_ptsr_sensor_d (.clk(dclk), .rstn(rstn), .press_in(prs_a), .temp_in(tmp_a),
    .link(link_d), .powered_reg(), .fresh_reg());
  ptsr_chk #(.HALF(HALF)) u_ptsr_chk (.clk(clk), .rstn(rstn), .sclk(link_a.sclk),
    .ss_line(link_a.ss_line), .al_d_oe(link_a.al_d_oe), .sda_d_oe(link_a.sda_d_oe));
  // Wire capture on the falling edge, where the data bit is settled
  always @(negedge link_a.sclk) cap_a <= {cap_a[30:0], link_a.sda_line};
  always @(negedge link_b.sclk) cap_b <= {cap_b[30:0], link_b.sda_line};
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("TB: %0d comparisons, %0d errors", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One fetch; judges host outputs and the bits seen on the wire
  task automatic fetch(input bit b, input logic [1:0] es, input logic [13:0] ep,
                       input logic [10:0] et);
    int n;
    // Each pair touches only its own request line: both pairs run at once
    @(posedge clk);
    if (b) begin
      rf_b <= 1'b1;
    end else begin
      rf_a <= 1'b1;
    end
    @(posedge clk);
    if (b) begin
      rf_b <= 1'b0;
    end else begin
      rf_a <= 1'b0;
    end
    for (n = 0; n < 12000; n++) begin
      @(negedge clk);
      if ((b ? done_b : done_a) === 1'b1) break;
    end
    `CHK("done", 1'b1, b ? done_b : done_a)
    `CHK("status", es, b ? st_b : st_a)
    `CHK("pressure", ep, b ? pr_b : pr_a)
    `CHK("temperature", et, b ? tp_b : tp_a)
    `CHK("wire word", {es, ep, et, PAD}, b ? cap_b : cap_a)
    for (n = 0; n < 1000; n++) begin
      @(negedge clk);
      if ((b ? busy_b : busy_a) === 1'b0) break;
    end
    `CHK("idle", 1'b0, b ? busy_b : busy_a)
  endtask
  task automatic wait_fresh(input bit b);
    int n;
    for (n = 0; n < 5000; n++) begin
      @(negedge clk);
      if ((b ? fr_b : fr_a) === 1'b1) break;
    end
    `CHK("fresh", 1'b1, b ? fr_b : fr_a)
  endtask
  // Two full update periods so a whole measurement sees the new inputs
  task automatic settle_a(input logic signed [19:0] p, input logic signed [15:0] t);
    @(posedge dclk);
    prs_a <= p;
    tmp_a <= t;
    repeat (2 * UPD + 20) @(posedge dclk);
    wait_fresh(1'b0);
  endtask
  task automatic scen_a;
    wait_fresh(1'b0);
    fetch(1'b0, ST_FRESH, P10_LO, 11'h000);
    `CHK("awake", 1'b1, pw_a)
    settle_a(20'h10000, 16'h05dc);
    fetch(1'b0, ST_FRESH, P10_HI, T_FULL);
    settle_a(20'h08000, 16'h0000);
    fetch(1'b0, ST_FRESH, P_MID, 11'h1ff);
    settle_a(20'hcf2c0, 16'h00fa);
    fetch(1'b0, ST_FRESH, P_ZERO, 11'h2ff);
  endtask
  // Low power: sleep, stale refetch, refused request, wake on request
  task automatic scen_b;
    int n;
    wait_fresh(1'b1);
    repeat (10) @(negedge clk);
    `CHK("asleep", 1'b0, pw_b)
    fetch(1'b1, ST_FRESH, P5_LO, T_FULL);
    fork
      fetch(1'b1, ST_STALE, P5_LO, T_FULL);
      begin
        repeat (100) @(posedge clk);
        rm_b <= 1'b1;
        @(posedge clk);
        rm_b <= 1'b0;
      end
    join
    `CHK("held", 1'b0, fr_b)
    `CHK("still asleep", 1'b0, pw_b)
    @(posedge dclk);
    prs_b <= 20'h10000;
    tmp_b <= 16'hfe0c;
    @(posedge clk);
    rm_b <= 1'b1;
    @(posedge clk);
    rm_b <= 1'b0;
    for (n = 0; n < 2000; n++) begin
      @(negedge clk);
      if (pw_b === 1'b1) break;
    end
    `CHK("woken", 1'b1, pw_b)
    wait_fresh(1'b1);
    repeat (10) @(negedge clk);
    `CHK("asleep again", 1'b0, pw_b)
    fetch(1'b1, ST_FRESH, P5_HI, 11'h000);
  endtask
  // I2C role: select pin becomes a data-ready alert; reduced part leaves it floating
  task automatic scen_c;
    int n;
    repeat (4) @(posedge dclk);
    @(negedge clk);
    `CHK("alert before data", 1'b0, link_c.ss_line)
    for (n = 0; n < 5000; n++) begin
      @(negedge clk);
      if (fr_c === 1'b1) break;
    end
    repeat (2) @(negedge clk);
    `CHK("alert on data", 1'b1, link_c.ss_line)
    `CHK("alert driven", 1'b1, link_c.al_d_oe)
    `CHK("no alert line", 1'b0, link_d.al_d_oe)
    `CHK("line floats", 1'b1, link_d.ss_line)
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    fork
      scen_a();
      scen_b();
      scen_c();
    join
    tally_and_finish();
  end
  // Pair A needs about 52k cycles; allow half as much again
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule
